//--- hw/acs_pkg.sv
// Shared constants and types of the converter calibration sequencer
package acs_pkg;

    // Bus geometry
    localparam int ACS_ADDR_W = 8;
    localparam int ACS_DATA_W = 32;
    localparam int ACS_RES_W = 14;
    localparam int ACS_SEL_W = 5;
    localparam int ACS_NUM_CH = 3;

    // Register indices; byte address is four times the index
    localparam logic [5:0] ACS_IDX_STATUS = 6'h00;
    localparam logic [5:0] ACS_IDX_CONFIG = 6'h01;
    localparam logic [5:0] ACS_IDX_CALCTL = 6'h02;
    localparam logic [5:0] ACS_IDX_CH1_CTL = 6'h06;
    localparam logic [5:0] ACS_IDX_CH1_LOW = 6'h07;
    localparam logic [5:0] ACS_IDX_CH1_HIGH = 6'h08;
    localparam logic [5:0] ACS_IDX_CH2_CTL = 6'h09;
    localparam logic [5:0] ACS_IDX_CH2_LOW = 6'h0a;
    localparam logic [5:0] ACS_IDX_CH2_HIGH = 6'h0b;
    localparam logic [5:0] ACS_IDX_CH3_CTL = 6'h0c;
    localparam logic [5:0] ACS_IDX_CH3_LOW = 6'h0d;
    localparam logic [5:0] ACS_IDX_CH3_HIGH = 6'h0e;
    localparam logic [5:0] ACS_IDX_OFFSET_CAL_LOW = 6'h14;
    localparam logic [5:0] ACS_IDX_OFFSET_CAL_HIGH = 6'h15;
    localparam logic [5:0] ACS_IDX_GAIN_ERROR_CAL_LOW = 6'h1c;
    localparam logic [5:0] ACS_IDX_GAIN_ERROR_CAL_HIGH = 6'h1d;
    localparam logic [5:0] ACS_IDX_IRQ_STATUS = 6'h20;
    localparam logic [5:0] ACS_IDX_IRQ_MASK = 6'h21;

    // Field positions
    localparam int ACS_BIT_ANALOG_INIT = 0;
    localparam int ACS_BIT_CONV_ENABLE = 0;
    localparam int ACS_BIT_FILTER_ENABLE = 1;
    localparam int ACS_BIT_OFFSET_CAL_EN = 0;
    localparam int ACS_BIT_GAIN_CAL_EN = 1;
    localparam int ACS_BIT_GAIN_VALID = 6;
    localparam int ACS_BIT_OFFSET_VALID = 7;
    localparam int ACS_BIT_CH_VALID = 7;
    localparam int ACS_BIT_CH_INT_EN = 5;
    localparam int ACS_LSB_LOW = 0;
    localparam int ACS_LSB_HIGH = 8;
    localparam int ACS_HIGH_W = 6;

    // Interrupt status bits: offset, gain, channel 1..3
    localparam int ACS_IRQ_W = 5;
    localparam int ACS_IRQ_OFFSET = 0;
    localparam int ACS_IRQ_GAIN = 1;
    localparam int ACS_IRQ_CH0 = 2;

    // Reset values
    localparam logic [ACS_SEL_W-1:0] ACS_SEL_RESET = 5'h1f;
    localparam logic [ACS_SEL_W-1:0] ACS_SEL_DISABLED = 5'h1f;
    localparam logic [ACS_IRQ_W-1:0] ACS_MASK_RESET = 5'h00;

    // Timing: 100 MHz clock, 1 us converter tick, 20 us per conversion
    localparam int ACS_CLK_PERIOD_NS = 10;
    localparam int ACS_TICK_NS = 1000;
    localparam int ACS_CONV_TIME_US = 20;
    localparam int ACS_TICK_DIV = ACS_TICK_NS / ACS_CLK_PERIOD_NS;
    localparam int ACS_CONV_TICKS = ACS_CONV_TIME_US * 1000 / ACS_TICK_NS;

    // Bus responses
    localparam logic [1:0] ACS_RESP_OKAY = 2'b00;
    localparam logic [1:0] ACS_RESP_SLVERR = 2'b10;

    // Converter job kinds as seen by the analogue front end
    typedef enum logic [1:0] {
        ACS_MODE_CHANNEL = 2'b00,
        ACS_MODE_OFFSET = 2'b01,
        ACS_MODE_GAIN = 2'b10
    } acs_mode_t;

    // Sequencer states
    typedef enum logic [1:0] {
        ACS_SEQ_IDLE = 2'b01,
        ACS_SEQ_BUSY = 2'b10
    } acs_seq_t;

endpackage : acs_pkg

//--- hw/acs_conv_engine.sv
// Conversion timer that drives the analogue front end and captures its code
`timescale 1ns/1ps
module acs_conv_engine (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Job request from the sequencer
    input wire logic start,
    input wire logic run,
    input wire acs_pkg::acs_mode_t mode,
    input wire logic [acs_pkg::ACS_SEL_W-1:0] sel,
    // Job completion
    output logic done,
    output logic [acs_pkg::ACS_RES_W-1:0] result,
    // Analogue front end
    output logic afe_convert,
    output acs_pkg::acs_mode_t afe_mode,
    output logic [acs_pkg::ACS_SEL_W-1:0] afe_select,
    input wire logic [acs_pkg::ACS_RES_W-1:0] afe_data
);
    import acs_pkg::*;

    typedef enum logic [1:0] {
        ACS_ENG_IDLE = 2'b01,
        ACS_ENG_RUN = 2'b10
    } acs_eng_t;

    typedef struct packed {
        acs_eng_t st;
        logic [6:0] div;
        logic [4:0] ticks;
        logic done;
        logic [ACS_RES_W-1:0] result;
        acs_mode_t mode;
        logic [ACS_SEL_W-1:0] sel;
    } acs_eng_state_t;

    acs_eng_state_t q, d;

    always_comb begin
        d = q;
        d.done = 1'b0;
        case (q.st)
            ACS_ENG_IDLE: begin
                d.div = '0;
                d.ticks = '0;
                if (start && run) begin
                    d.st = ACS_ENG_RUN;
                    d.mode = mode;
                    d.sel = sel;
                end
            end
            ACS_ENG_RUN: begin
                // Dropping the enable abandons the job so the front end powers down at once
                if (!run) begin
                    d.st = ACS_ENG_IDLE;
                end else if (q.div == 7'(ACS_TICK_DIV - 1)) begin
                    d.div = '0;
                    if (q.ticks == 5'(ACS_CONV_TICKS - 1)) begin
                        d.st = ACS_ENG_IDLE;
                        d.done = 1'b1;
                        d.result = afe_data;
                    end else begin
                        d.ticks = q.ticks + 5'd1;
                    end
                end else begin
                    d.div = q.div + 7'd1;
                end
            end
            default: d.st = ACS_ENG_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{st: ACS_ENG_IDLE, mode: ACS_MODE_CHANNEL, sel: ACS_SEL_DISABLED, default: '0};
        end else begin
            q <= d;
        end
    end

    assign done = q.done;
    assign result = q.result;
    assign afe_convert = (q.st == ACS_ENG_RUN);
    assign afe_mode = q.mode;
    assign afe_select = q.sel;

endmodule : acs_conv_engine

//--- hw/acs_sequencer.sv
// Register file, calibration sequencing and result capture of the converter
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps

// What this block does
// R1: Offset result readable at 0x14 and 0x15
// R2: Gain-error result readable at 0x1c and 0x1d
// R3: Software reads results then clears valid flag
// R4: Software pulses analogue-init once after power-up
// R5: Software sets filter enable during initialisation
// R6: Offset calibration starts on enable plus converter enable
// R7: Offset-valid flag set when offset result ready
// R8: Gain calibration sets gain-valid flag when done
// R9: Software clears converter enable after each job; the sequencer starts the next pending job while it stays set
// R10: Software enables channel and sets input select
// R11: Converter enable starts channel conversion
// R12: Channel data-valid flag set on conversion finish
// R13: Software calibrates results, skips repeat calibration
// R14: Software maps threshold low boundary once
// R15: High boundary is low boundary plus seven
// R16: Valid flags sticky; no new result while set
module acs_sequencer (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // AXI4-Lite write address and data
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [acs_pkg::ACS_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [acs_pkg::ACS_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [acs_pkg::ACS_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [acs_pkg::ACS_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Interrupt
    output logic irq,
    // Analogue front end
    output logic afe_init,
    output logic afe_power,
    output logic afe_filter,
    output logic afe_convert,
    output acs_pkg::acs_mode_t afe_mode,
    output logic [acs_pkg::ACS_SEL_W-1:0] afe_select,
    input wire logic [acs_pkg::ACS_RES_W-1:0] afe_data
);
    import acs_pkg::*;

    typedef struct packed {
        logic aw_pend;
        logic [ACS_ADDR_W-1:0] aw_addr;
        logic w_pend;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [ACS_DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic analog_init_bit;
        logic converter_enable;
        logic filter_enable;
        logic offset_cal_enable;
        logic gain_cal_enable;
        logic offset_valid_flag;
        logic gain_valid_flag;
        logic [ACS_RES_W-1:0] offset_cal_value;
        logic [ACS_RES_W-1:0] gain_error_value;
        logic [ACS_NUM_CH-1:0] channel_result_valid;
        logic [ACS_NUM_CH-1:0] ch_int_en;
        logic [ACS_NUM_CH-1:0][ACS_SEL_W-1:0] input_select;
        logic [ACS_NUM_CH-1:0][ACS_RES_W-1:0] ch_result;
        logic [ACS_IRQ_W-1:0] irq_sts;
        logic [ACS_IRQ_W-1:0] irq_mask;
        acs_seq_t st;
        logic [2:0] job;
    } acs_state_t;

    acs_state_t q, d;
    logic eng_start;
    logic eng_done;
    logic [ACS_RES_W-1:0] eng_result;
    acs_mode_t job_mode;
    logic [ACS_SEL_W-1:0] job_sel;

    localparam logic [5:0] CH_CTL_IDX [ACS_NUM_CH] = '{ACS_IDX_CH1_CTL, ACS_IDX_CH2_CTL, ACS_IDX_CH3_CTL};
    localparam logic [5:0] CH_LOW_IDX [ACS_NUM_CH] = '{ACS_IDX_CH1_LOW, ACS_IDX_CH2_LOW, ACS_IDX_CH3_LOW};
    localparam logic [5:0] CH_HIGH_IDX [ACS_NUM_CH] = '{ACS_IDX_CH1_HIGH, ACS_IDX_CH2_HIGH, ACS_IDX_CH3_HIGH};

    // Answers hit, and data for a readable word; unmapped words read zero
    function automatic logic [8:0] read_word(input acs_state_t s, input logic [ACS_ADDR_W-1:0] addr);
        logic [5:0] idx;
        logic [8:0] r;
        idx = addr[ACS_ADDR_W-1:2];
        r = '0;
        if (addr[1:0] != 2'b00) begin
            r = '0;
        end else if (idx == ACS_IDX_STATUS) begin
            r = {1'b1, 7'h00, s.analog_init_bit};
        end else if (idx == ACS_IDX_CONFIG) begin
            r = {1'b1, 6'h00, s.filter_enable, s.converter_enable};
        end else if (idx == ACS_IDX_CALCTL) begin
            r = {1'b1, s.offset_valid_flag, s.gain_valid_flag, 4'h0, s.gain_cal_enable, s.offset_cal_enable};
        // R1: offset result words
        end else if (idx == ACS_IDX_OFFSET_CAL_LOW) begin
            r = {1'b1, s.offset_cal_value[ACS_LSB_HIGH-1:ACS_LSB_LOW]};
        end else if (idx == ACS_IDX_OFFSET_CAL_HIGH) begin
            r = {1'b1, 2'b00, s.offset_cal_value[ACS_RES_W-1:ACS_LSB_HIGH]};
        // R2: gain-error result words
        end else if (idx == ACS_IDX_GAIN_ERROR_CAL_LOW) begin
            r = {1'b1, s.gain_error_value[ACS_LSB_HIGH-1:ACS_LSB_LOW]};
        end else if (idx == ACS_IDX_GAIN_ERROR_CAL_HIGH) begin
            r = {1'b1, 2'b00, s.gain_error_value[ACS_RES_W-1:ACS_LSB_HIGH]};
        end else if (idx == ACS_IDX_IRQ_STATUS) begin
            r = {1'b1, 3'b000, s.irq_sts};
        end else if (idx == ACS_IDX_IRQ_MASK) begin
            r = {1'b1, 3'b000, s.irq_mask};
        end else begin
            for (int i = 0; i < ACS_NUM_CH; i++) begin
                if (idx == CH_CTL_IDX[i]) begin
                    r = {1'b1, s.channel_result_valid[i], 1'b0, s.ch_int_en[i], s.input_select[i]};
                end else if (idx == CH_LOW_IDX[i]) begin
                    r = {1'b1, s.ch_result[i][ACS_LSB_HIGH-1:ACS_LSB_LOW]};
                end else if (idx == CH_HIGH_IDX[i]) begin
                    r = {1'b1, 2'b00, s.ch_result[i][ACS_RES_W-1:ACS_LSB_HIGH]};
                end
            end
        end
        return r;
    endfunction : read_word

    always_comb begin
        logic [5:0] widx;
        logic wr;
        logic [8:0] rw;
        logic [8:0] ww;
        logic picked;
        d = q;
        widx = q.aw_addr[ACS_ADDR_W-1:2];
        wr = q.aw_pend && q.w_pend && !q.bvalid;
        rw = read_word(q, s_axi_araddr);
        ww = read_word(q, q.aw_addr);
        picked = 1'b0;
        eng_start = 1'b0;

        // Address and data are taken independently and paired here
        if (s_axi_awvalid && !q.aw_pend) begin
            d.aw_pend = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.w_pend) begin
            d.w_pend = 1'b1;
            d.w_data = s_axi_wdata[7:0];
            d.w_lane0 = s_axi_wstrb[0];
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (wr) begin
            d.aw_pend = 1'b0;
            d.w_pend = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = ww[8] ? ACS_RESP_OKAY : ACS_RESP_SLVERR;
        end

        // Writes; flag clears land first so that a same-cycle set below wins
        if (wr && q.w_lane0 && ww[8]) begin
            if (widx == ACS_IDX_STATUS) begin
                d.analog_init_bit = q.w_data[ACS_BIT_ANALOG_INIT];
            end else if (widx == ACS_IDX_CONFIG) begin
                d.converter_enable = q.w_data[ACS_BIT_CONV_ENABLE];
                d.filter_enable = q.w_data[ACS_BIT_FILTER_ENABLE];
            end else if (widx == ACS_IDX_CALCTL) begin
                d.offset_cal_enable = q.w_data[ACS_BIT_OFFSET_CAL_EN];
                d.gain_cal_enable = q.w_data[ACS_BIT_GAIN_CAL_EN];
                // R16: flags leave only on a write of one
                d.offset_valid_flag = q.offset_valid_flag & ~q.w_data[ACS_BIT_OFFSET_VALID];
                d.gain_valid_flag = q.gain_valid_flag & ~q.w_data[ACS_BIT_GAIN_VALID];
            end else if (widx == ACS_IDX_IRQ_STATUS) begin
                d.irq_sts = q.irq_sts & ~q.w_data[ACS_IRQ_W-1:0];
            end else if (widx == ACS_IDX_IRQ_MASK) begin
                d.irq_mask = q.w_data[ACS_IRQ_W-1:0];
            end else begin
                for (int i = 0; i < ACS_NUM_CH; i++) begin
                    if (widx == CH_CTL_IDX[i]) begin
                        d.input_select[i] = q.w_data[ACS_SEL_W-1:0];
                        d.ch_int_en[i] = q.w_data[ACS_BIT_CH_INT_EN];
                        d.channel_result_valid[i] = q.channel_result_valid[i] & ~q.w_data[ACS_BIT_CH_VALID];
                    end
                end
            end
        end

        // Read answer is registered; one read outstanding at a time
        if (s_axi_arvalid && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rdata = {24'h000000, rw[7:0]};
            d.rresp = rw[8] ? ACS_RESP_OKAY : ACS_RESP_SLVERR;
        end else if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end

        case (q.st)
            ACS_SEQ_IDLE: begin
                // R6: offset job waits for both enables
                if (q.converter_enable && q.offset_cal_enable && !q.offset_valid_flag) begin
                    d.job = 3'd0;
                    picked = 1'b1;
                // R8: gain job follows the offset
                end else if (q.converter_enable && q.gain_cal_enable && !q.gain_valid_flag) begin
                    d.job = 3'd1;
                    picked = 1'b1;
                end else if (q.converter_enable) begin
                    // R16: a channel with a pending result is skipped
                    for (int i = ACS_NUM_CH - 1; i >= 0; i--) begin
                        if (q.input_select[i] != ACS_SEL_DISABLED && !q.channel_result_valid[i]) begin
                            d.job = 3'(i + 2);
                            picked = 1'b1;
                        end
                    end
                end
                if (picked) begin
                    eng_start = 1'b1;
                    d.st = ACS_SEQ_BUSY;
                end
            end
            ACS_SEQ_BUSY: begin
                if (!q.converter_enable) begin
                    d.st = ACS_SEQ_IDLE;
                end else if (eng_done) begin
                    d.st = ACS_SEQ_IDLE;
                    if (q.job == 3'd0) begin
                        // R7: offset result with its valid flag
                        d.offset_cal_value = eng_result;
                        d.offset_valid_flag = 1'b1;
                        d.irq_sts[ACS_IRQ_OFFSET] = 1'b1;
                    end else if (q.job == 3'd1) begin
                        // R8: gain result with its valid flag
                        d.gain_error_value = eng_result;
                        d.gain_valid_flag = 1'b1;
                        d.irq_sts[ACS_IRQ_GAIN] = 1'b1;
                    end else begin
                        for (int i = 0; i < ACS_NUM_CH; i++) begin
                            if (q.job == 3'(i + 2)) begin
                                // R12: channel result with its valid flag
                                d.ch_result[i] = eng_result;
                                d.channel_result_valid[i] = 1'b1;
                                d.irq_sts[ACS_IRQ_CH0 + i] = 1'b1;
                            end
                        end
                    end
                end
            end
            default: d.st = ACS_SEQ_IDLE;
        endcase
    end

    // Front end job descriptors come from the state being entered
    always_comb begin
        job_mode = ACS_MODE_CHANNEL;
        job_sel = ACS_SEL_DISABLED;
        if (d.job == 3'd0) begin
            job_mode = ACS_MODE_OFFSET;
        end else if (d.job == 3'd1) begin
            job_mode = ACS_MODE_GAIN;
        end else begin
            for (int i = 0; i < ACS_NUM_CH; i++) begin
                if (d.job == 3'(i + 2)) begin
                    job_sel = q.input_select[i];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{st: ACS_SEQ_IDLE,
                   input_select: {ACS_NUM_CH{ACS_SEL_RESET}},
                   irq_mask: ACS_MASK_RESET,
                   default: '0};
        end else begin
            q <= d;
        end
    end

    // R11: converter enable drives the conversion engine
    acs_conv_engine u_engine (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .start(eng_start),
        .run(q.converter_enable),
        .mode(job_mode),
        .sel(job_sel),
        .done(eng_done),
        .result(eng_result),
        .afe_convert(afe_convert),
        .afe_mode(afe_mode),
        .afe_select(afe_select),
        .afe_data(afe_data)
    );

    assign s_axi_awready = !q.aw_pend;
    assign s_axi_wready = !q.w_pend;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign irq = |(q.irq_sts & q.irq_mask);
    assign afe_init = q.analog_init_bit;
    assign afe_power = q.converter_enable;
    assign afe_filter = q.filter_enable;

endmodule : acs_sequencer

//--- testbench/acs_seq_chk.sv
// Port-level checks of the converter calibration sequencer
`timescale 1ns/1ps
module acs_seq_chk (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [acs_pkg::ACS_DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    // Interrupt and front end
    input wire logic irq,
    input wire logic afe_power,
    input wire logic afe_convert,
    input wire acs_pkg::acs_mode_t afe_mode,
    input wire logic [acs_pkg::ACS_SEL_W-1:0] afe_select
);
    import acs_pkg::*;
    localparam int CONV_CYCLES = ACS_CONV_TICKS * ACS_TICK_DIV;
    logic [11:0] conv_cnt_q;
    logic [11:0] conv_cnt_d;
    // Too long for a repetition, so the high time is counted here
    always_comb conv_cnt_d = afe_convert ? conv_cnt_q + 12'h001 : 12'h000;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            conv_cnt_q <= 12'h000;
        end else begin
            conv_cnt_q <= conv_cnt_d;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_bvalid_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_ar_blocked: assert property (s_axi_arready == !s_axi_rvalid) else $error("read accepted while busy");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000) else $error("upper read bits set");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer late");
    a_conv_len: assert property (afe_convert |-> conv_cnt_q < 12'(CONV_CYCLES)) else $error("conversion too long");
    a_conv_done: assert property (
        $fell(afe_convert) && afe_power |-> conv_cnt_q == 12'(CONV_CYCLES)) else $error("conversion too short");
    a_power_abort: assert property ($fell(afe_power) |-> ##[0:2] !afe_convert) else $error("job not aborted");
    a_cal_select: assert property (
        afe_convert && afe_mode != ACS_MODE_CHANNEL |-> afe_select == ACS_SEL_DISABLED) else $error("cal select wrong");
    c_irq_rise: cover property ($rose(irq));
    c_conv_end: cover property ($fell(afe_convert) && afe_power);
    c_read_err: cover property (s_axi_rvalid && s_axi_rresp == ACS_RESP_SLVERR);
endmodule : acs_seq_chk

//--- testbench/tb.sv
// Self-checking bench of the converter calibration sequencer
`timescale 1ns/1ps
module tb;
    import acs_pkg::*;
    logic clk_sys, rst_n, irq, afe_init, afe_power, afe_filter, afe_convert;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [ACS_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [ACS_DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] s_axi_wstrb;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    acs_mode_t afe_mode;
    logic [ACS_SEL_W-1:0] afe_select;
    logic [ACS_RES_W-1:0] afe_data;
    int n_errors, checks;
    acs_sequencer acs_sequencer_i (.*);
    task automatic print_verdict();
        if (n_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic timeout();
        n_errors++;
        $display("mismatch at %0t: wait ran out", $time);
        print_verdict();
    endtask : timeout
    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        int n = 0;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (++n > 50) timeout();
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (++n > 50) timeout();
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk_sys);
    endtask : rd
    task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(idx, d, r);
        chk(d, exp);
        chk({30'h0, r}, {30'h0, ACS_RESP_OKAY});
    endtask : rdc
    task automatic wait_irq();
        int n = 0;
        while (irq !== 1'b1) begin
            @(posedge clk_sys);
            if (++n > 3000) timeout();
        end
    endtask : wait_irq
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        rdc(ACS_IDX_CH1_CTL, 32'h1f);
        rdc(ACS_IDX_CALCTL, 32'h0);
        rd(6'h3f, d, r);
        chk({30'h0, r}, {30'h0, ACS_RESP_SLVERR});
        chk(d, 32'h0);
        wr(ACS_IDX_OFFSET_CAL_LOW, 32'hff);
        rdc(ACS_IDX_OFFSET_CAL_LOW, 32'h0);
    endtask : t_reset
    task automatic t_offset();
        wr(ACS_IDX_STATUS, 32'h1);
        chk(32'(afe_init), 32'h1);
        wr(ACS_IDX_STATUS, 32'h0);
        wr(ACS_IDX_CONFIG, 32'h2);
        chk(32'(afe_filter), 32'h1);
        wr(ACS_IDX_IRQ_MASK, 32'h1f);
        afe_data <= 14'h2a5b;
        wr(ACS_IDX_CALCTL, 32'h1);
        wr(ACS_IDX_CONFIG, 32'h3);
        wait_irq();
        rdc(ACS_IDX_CALCTL, 32'h81);
        rdc(ACS_IDX_OFFSET_CAL_LOW, 32'h5b);
        rdc(ACS_IDX_OFFSET_CAL_HIGH, 32'h2a);
        rdc(ACS_IDX_IRQ_STATUS, 32'h1);
    endtask : t_offset
    task automatic t_gain();
        afe_data <= 14'h1c3d;
        wr(ACS_IDX_IRQ_STATUS, 32'h1);
        chk(32'(irq), 32'h0);
        // Clears the offset flag with its enable off, so only gain runs
        wr(ACS_IDX_CALCTL, 32'h82);
        wait_irq();
        rdc(ACS_IDX_CALCTL, 32'h42);
        rdc(ACS_IDX_GAIN_ERROR_CAL_LOW, 32'h3d);
        rdc(ACS_IDX_GAIN_ERROR_CAL_HIGH, 32'h1c);
        rdc(ACS_IDX_OFFSET_CAL_LOW, 32'h5b);
    endtask : t_gain
    task automatic t_sticky();
        afe_data <= 14'h0777;
        wr(ACS_IDX_IRQ_STATUS, 32'h2);
        // Longer than one conversion: a rerun would land inside it
        repeat (2100) @(posedge clk_sys);
        chk(32'(irq), 32'h0);
        rdc(ACS_IDX_GAIN_ERROR_CAL_LOW, 32'h3d);
    endtask : t_sticky
    task automatic t_channel();
        logic [31:0] lo, hi;
        logic [1:0] r;
        int raw, rbl;
        wr(ACS_IDX_CONFIG, 32'h2);
        chk(32'(afe_power), 32'h0);
        wr(ACS_IDX_CALCTL, 32'h40);
        wr(ACS_IDX_CH1_CTL, 32'h0);
        afe_data <= 14'h3e01;
        wr(ACS_IDX_CONFIG, 32'h3);
        wait_irq();
        rdc(ACS_IDX_CH1_CTL, 32'h80);
        rdc(ACS_IDX_CH1_LOW, 32'h01);
        rdc(ACS_IDX_CH1_HIGH, 32'h3e);
        rd(ACS_IDX_CH1_HIGH, hi, r);
        rd(ACS_IDX_CH1_LOW, lo, r);
        raw = int'({hi[5:0], lo[7:0]});
        // Zero threshold maps onto the offset word
        rbl = (int'(14'h1c3d) - int'(14'h2a5b)) * (0 << 3) / 8191 + int'(14'h2a5b);
        chk(32'(raw >= rbl), 32'h1);
        chk(32'(raw <= rbl + 7), 32'h0);
        wr(ACS_IDX_CONFIG, 32'h2);
    endtask : t_channel
    task automatic t_mask();
        wr(ACS_IDX_IRQ_MASK, 32'h0);
        chk(32'(irq), 32'h0);
        rdc(ACS_IDX_IRQ_STATUS, 32'h4);
        wr(ACS_IDX_IRQ_MASK, 32'h4);
        chk(32'(irq), 32'h1);
        wr(ACS_IDX_IRQ_STATUS, 32'h4);
        chk(32'(irq), 32'h0);
    endtask : t_mask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        n_errors = 0;
        checks = 0;
        rst_n = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {s_axi_awprot, s_axi_arprot} = 6'h00;
        s_axi_wstrb = 4'hf;
        afe_data = 14'h0000;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_offset();
        t_gain();
        t_sticky();
        t_channel();
        t_mask();
        print_verdict();
    end
endmodule : tb
bind acs_sequencer acs_seq_chk acs_seq_chk_i (.*);
